// *** auto_reload_interval_timer.sv ***
// APB register core, up counter, auto-reload and interrupt request of the interval timer
//
// The APB register port is this design's own decision.
`default_nettype none
module auto_reload_interval_timer
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_event_pin,
  input wire logic cpu_irq_mask,
  output logic timer_irq_req
);
  typedef enum logic [2:0] {
    REG_NONE,
    REG_MODE,
    REG_COUNT,
    REG_IEN,
    REG_IRQ
  } reg_sel_e;

  tick_source_if ts ();

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic auto_q;
  logic [2:0] sel_q;
  logic [7:0] count_q;
  logic [7:0] reload_q;
  logic ien_q;
  logic flag_q;
  logic irq_q;
  logic access;
  logic wr_en;
  reg_sel_e wr_sel;
  reg_sel_e rd_sel;
  logic overflow;
  logic load_wr;
  logic flag_clr;
  logic [31:0] rd_data;

  // Any access to the four mapped, aligned word addresses answers without error, whatever the byte strobes
  function automatic reg_sel_e decode(input logic [ADDR_W-1:0] addr);
    reg_sel_e s;
    s = REG_NONE;
    if (addr == MODE_ADDR) begin
      s = REG_MODE;
    end else if (addr == COUNT_ADDR) begin
      s = REG_COUNT;
    end else if (addr == IEN_ADDR) begin
      s = REG_IEN;
    end else if (addr == IRQ_ADDR) begin
      s = REG_IRQ;
    end
    return s;
  endfunction

  assign ts.sel = sel_q;
  assign ts.ext_pin = ext_event_pin;

  count_clock_select u_clk_sel (
    .pclk(pclk),
    .presetn(presetn),
    .ts(ts)
  );

  // Bus side: one wait state, the write lands on the edge that samples pready
  assign access = psel && penable && pready_q;
  assign wr_sel = decode(paddr);
  assign rd_sel = decode(paddr);
  assign wr_en = access && pwrite && pstrb[0];
  assign load_wr = wr_en && (wr_sel == REG_COUNT);
  // Writing zero to the flag clears it; writing one leaves it alone
  assign flag_clr = wr_en && (wr_sel == REG_IRQ) && !pwdata[IRQ_BIT];
  assign overflow = ts.tick && (count_q == COUNT_MAX);

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_sel)
      REG_NONE: rd_data = 32'h0000_0000;
      REG_MODE: rd_data = {24'h000000, auto_q, MODE_RSV_ONES, sel_q};
      REG_COUNT: rd_data = {24'h000000, count_q};
      REG_IEN: rd_data = {26'h0000000, ien_q, 5'h00};
      REG_IRQ: rd_data = {26'h0000000, flag_q, 5'h00};
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= (rd_sel == REG_NONE);
      prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_q <= RST_AUTO;
      sel_q <= RST_SEL;
    end else if (wr_en && wr_sel == REG_MODE) begin
      auto_q <= pwdata[MODE_AUTO_BIT];
      sel_q <= pwdata[MODE_SEL_LSB +: MODE_SEL_W];
    end
  end

  // Load register: the count reads back at this index, so the value is write-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= RST_RELOAD;
    end else if (load_wr) begin
      reload_q <= pwdata[7:0];
    end
  end

  // A load write restarts the count from the new value and beats a tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= RST_COUNT;
    end else if (load_wr) begin
      count_q <= pwdata[7:0];
    end else if (overflow) begin
      count_q <= auto_q ? reload_q : RST_COUNT;
    end else if (ts.tick) begin
      count_q <= count_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= RST_IEN;
    end else if (wr_en && wr_sel == REG_IEN) begin
      ien_q <= pwdata[IRQ_BIT];
    end
  end

  // An overflow in the clearing cycle wins, so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= RST_FLAG;
    end else if (overflow) begin
      flag_q <= 1'b1;
    end else if (flag_clr) begin
      flag_q <= 1'b0;
    end
  end

  // The mask comes from CPU logic on this clock, so it is used unsynchronised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flag_q && ien_q && !cpu_irq_mask;
    end
  end

  assign timer_irq_req = irq_q;

  // Helper: ticks since the last overflow, valid only over an undisturbed period
  logic [7:0] ivl_cnt_q;
  logic ivl_ok_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ivl_cnt_q <= 8'h00;
      ivl_ok_q <= 1'b0;
    end else begin
      if (overflow) begin
        ivl_cnt_q <= 8'h00;
      end else if (ts.tick) begin
        ivl_cnt_q <= ivl_cnt_q + 8'h01;
      end
      if (wr_en && (wr_sel == REG_MODE || wr_sel == REG_COUNT)) begin
        ivl_ok_q <= 1'b0;
      end else if (overflow) begin
        ivl_ok_q <= auto_q;
      end
    end
  end

  AST_MODE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && wr_sel == REG_MODE |=>
      auto_q == $past(pwdata[MODE_AUTO_BIT]) && sel_q == $past(pwdata[2:0]))
    else $error("mode register did not take the written value");

  AST_MODE_READ: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready_q && !pwrite && rd_sel == REG_MODE |=>
      pready && prdata[7:0] == {auto_q, MODE_RSV_ONES, sel_q} && prdata[31:8] == 24'h0)
    else $error("mode register read back wrong");

  AST_COUNT_UP: assert property (@(posedge pclk) disable iff (!presetn)
    ts.tick && !load_wr && count_q != COUNT_MAX |=> count_q == $past(count_q) + 8'h01)
    else $error("count did not advance on a tick");

  AST_COUNT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !ts.tick && !load_wr |=> $stable(count_q))
    else $error("count moved without a tick");

  AST_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    load_wr |=> reload_q == $past(pwdata[7:0]) && count_q == reload_q)
    else $error("load write did not set reload and count");

  AST_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
    overflow && !load_wr && auto_q |=> count_q == $past(reload_q) && flag_q)
    else $error("auto-reload did not reload on overflow");

  AST_WRAP_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    overflow && !load_wr && !auto_q |=> count_q == RST_COUNT)
    else $error("free count did not wrap to zero");

  AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |=> flag_q)
    else $error("overflow did not set the request flag");

  AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    flag_q && !flag_clr |=> flag_q)
    else $error("request flag dropped without a clear");

  AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    flag_clr && !overflow |=> !flag_q)
    else $error("writing zero did not clear the flag");

  AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    timer_irq_req == ($past(flag_q) && $past(ien_q) && !$past(cpu_irq_mask)))
    else $error("interrupt request does not follow flag, enable and mask");

  AST_IRQ_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
    flag_q && !ien_q |=> !timer_irq_req)
    else $error("disabled flag reached the interrupt output");

  AST_INTERVAL: assert property (@(posedge pclk) disable iff (!presetn)
    overflow && ivl_ok_q && auto_q |->
      ({1'b0, ivl_cnt_q} + 9'h001) == (COUNT_SPAN - {1'b0, reload_q}))
    else $error("interrupt interval is not 256 minus reload ticks");

  AST_MODE_FC: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && wr_sel == REG_MODE && pwdata[7:0] == MODE_AUTO_DIV64 |=>
      auto_q && sel_q == SEL_DIV64)
    else $error("mode fc did not pick auto-reload over 64");

  AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready_q && rd_sel == REG_NONE |=> pready && pslverr)
    else $error("unmapped access not answered with an error");

  // Bus handshake: one wait state, answer signals stand for one cycle only
  AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready stood longer than one cycle");

  AST_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait state");

  AST_RDATA_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("read data or error shown outside the ready cycle");

  AST_STRB_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && !pstrb[0] |=>
      $stable(auto_q) && $stable(sel_q) && $stable(reload_q) && $stable(ien_q))
    else $error("write with the low byte strobe off changed a register");

  AST_FLAG_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    !flag_q && !overflow |=> !flag_q)
    else $error("request flag rose without an overflow");

  AST_IRQ_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_irq_mask |=> !timer_irq_req)
    else $error("masked request reached the interrupt output");

  COV_AUTO_RELOAD: cover property (@(posedge pclk) disable iff (!presetn)
    overflow && auto_q ##1 count_q == reload_q);

  COV_IRQ_RAISED: cover property (@(posedge pclk) disable iff (!presetn)
    !timer_irq_req ##1 timer_irq_req);

  COV_EXT_TICK: cover property (@(posedge pclk) disable iff (!presetn)
    ts.tick && sel_q == SEL_EXT);

  COV_SET_WINS: cover property (@(posedge pclk) disable iff (!presetn)
    overflow && flag_clr);

  COV_FREE_WRAP: cover property (@(posedge pclk) disable iff (!presetn)
    overflow && !auto_q);
endmodule // auto_reload_interval_timer
`default_nettype wire

// *** auto_reload_interval_timer_bench.sv ***
// Self-checking bench of the auto-reload interval timer
`default_nettype none
module auto_reload_interval_timer_bench
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_event_pin = 1'b0;
  logic cpu_irq_mask;
  logic mask_req = 1'b1;
  logic timer_irq_req;
  logic [31:0] rdv;
  logic err;
  int taken_count;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;

  auto_reload_interval_timer dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ext_event_pin(ext_event_pin),
    .cpu_irq_mask(cpu_irq_mask),
    .timer_irq_req(timer_irq_req)
  );

  cpu_irq_model cpu (
    .pclk(pclk),
    .presetn(presetn),
    .mask_req(mask_req),
    .timer_irq_req(timer_irq_req),
    .cpu_irq_mask(cpu_irq_mask),
    .taken_count(taken_count)
  );

  always #12.5 pclk = ~pclk;

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Whole run needs about 30000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      $display("[ERR] %0t run timed out", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk(pready, 1'b1);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    apb(1'b0, a, 32'h0, 4'hf);
  endtask

  // Sampled at the edge, so both rises of a pair carry the same offset
  task automatic wait_irq(output int t);
    int n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (timer_irq_req !== 1'b1 && n < 20000);
    t = cyc;
    chk(timer_irq_req, 1'b1);
  endtask

  task automatic t_reset_regs();
    rd(MODE_ADDR);
    chk(rdv, {24'h0, RST_AUTO, MODE_RSV_ONES, RST_SEL});
    rd(COUNT_ADDR);
    chk(rdv, {24'h0, RST_COUNT});
    rd(IEN_ADDR);
    chk(rdv, 32'h0);
    rd(IRQ_ADDR);
    chk(rdv, 32'h0);
    rd(18'h0);
    chk(err, 1'b1);
    apb(1'b1, MODE_ADDR, 32'hfc, 4'h0);
    rd(MODE_ADDR);
    chk(rdv, 32'h78);
    wr(MODE_ADDR, {24'h0, MODE_AUTO_DIV64});
    rd(MODE_ADDR);
    chk(rdv, 32'hfc);
  endtask

  task automatic t_interval();
    int per[7] = '{8192, 2048, 512, 256, 64, 16, 4};
    logic [7:0] rel[7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'he7, 8'hf8, 8'he0};
    int t0;
    int t1;
    wr(IEN_ADDR, 32'h20);
    rd(IEN_ADDR);
    chk(rdv, 32'h20);
    mask_req <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      wr(MODE_ADDR, 32'(32'hf8 + i));
      wr(COUNT_ADDR, {24'h0, rel[i]});
      wr(IRQ_ADDR, 32'h0);
      repeat (2) @(posedge pclk);
      wait_irq(t0);
      // Fast taps move on before a read could finish
      if (i <= 4) begin
        rd(COUNT_ADDR);
        chk(rdv, {24'h0, rel[i]});
      end
      wr(IRQ_ADDR, 32'h0);
      repeat (2) @(posedge pclk);
      wait_irq(t1);
      chk(32'(t1 - t0), 32'(per[i] * (256 - rel[i])));
    end
  endtask

  task automatic t_mask();
    wr(MODE_ADDR, 32'h87);
    chk(timer_irq_req, 1'b1);
    mask_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(timer_irq_req, 1'b0);
    mask_req <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(timer_irq_req, 1'b1);
    wr(IEN_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    chk(timer_irq_req, 1'b0);
    rd(IRQ_ADDR);
    chk(rdv, 32'h20);
    wr(IRQ_ADDR, 32'h20);
    rd(IRQ_ADDR);
    chk(rdv, 32'h20);
    wr(IRQ_ADDR, 32'h0);
    rd(IRQ_ADDR);
    chk(rdv, 32'h0);
    chk(32'(taken_count > 0), 32'h1);
  endtask

  task automatic t_ext();
    wr(COUNT_ADDR, 32'hfd);
    wr(IEN_ADDR, 32'h20);
    for (int k = 1; k <= 3; k++) begin
      ext_event_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_event_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      chk(timer_irq_req, (k == 3));
    end
    rd(COUNT_ADDR);
    chk(rdv, 32'hfd);
    // Free-running mode: the wrap goes to zero, not to the load value
    wr(IRQ_ADDR, 32'h0);
    wr(MODE_ADDR, 32'h07);
    rd(MODE_ADDR);
    chk(rdv, 32'h7f);
    wr(COUNT_ADDR, 32'hff);
    ext_event_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_event_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(COUNT_ADDR);
    chk(rdv, {24'h0, RST_COUNT});
    rd(IRQ_ADDR);
    chk(rdv, 32'h20);
  endtask

  // Reset in mid-run drops the request and returns the registers to idle
  task automatic t_reset_mid();
    chk(timer_irq_req, 1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(timer_irq_req, 1'b0);
    presetn <= 1'b1;
    rd(IRQ_ADDR);
    chk(rdv, 32'h0);
    chk(err, 1'b0);
    rd(MODE_ADDR);
    chk(rdv, {24'h0, RST_AUTO, MODE_RSV_ONES, RST_SEL});
    rd(COUNT_ADDR);
    chk(rdv, {24'h0, RST_COUNT});
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_regs();
    t_interval();
    t_mask();
    t_ext();
    t_reset_mid();
    end_of_test();
  end
endmodule // auto_reload_interval_timer_bench
`default_nettype wire

// *** count_clock_select.sv ***
// Prescaler and count clock selector producing one-cycle count ticks
`default_nettype none
module count_clock_select
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  tick_source_if.src ts
);
  logic [PRESC_W-1:0] presc_q;
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic tick_q;
  logic tick_d;

  // Low bits that must all be one for a tap to fire once per period
  function automatic logic [PRESC_W-1:0] tap_mask(input logic [2:0] sel);
    logic [PRESC_W-1:0] m;
    m = '0;
    unique case (sel)
      SEL_DIV8192: m = 13'h1fff;
      SEL_DIV2048: m = 13'h07ff;
      SEL_DIV512: m = 13'h01ff;
      SEL_DIV256: m = 13'h00ff;
      SEL_DIV64: m = 13'h003f;
      SEL_DIV16: m = 13'h000f;
      SEL_DIV4: m = 13'h0003;
      SEL_EXT: m = 13'h0000;
    endcase
    return m;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 13'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= ts.ext_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // External events count on the rising edge of the pin
  always_comb begin
    if (ts.sel == SEL_EXT) begin
      tick_d = sync2_q && !sync3_q;
    end else begin
      tick_d = ((presc_q & tap_mask(ts.sel)) == tap_mask(ts.sel));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
    end
  end

  assign ts.tick = tick_q;

  AST_DIV4_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
    (ts.sel == SEL_DIV4) [*5] ##1 ts.tick |->
      !$past(ts.tick, 1) && !$past(ts.tick, 2) && !$past(ts.tick, 3) && $past(ts.tick, 4))
    else $error("divide-by-4 tick spacing is not four cycles");
endmodule // count_clock_select
`default_nettype wire

// *** cpu_irq_model.sv ***
// Behavioural CPU interrupt acceptance logic facing the timer
`default_nettype none
module cpu_irq_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mask_req,
  input wire logic timer_irq_req,
  output logic cpu_irq_mask,
  output int taken_count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic irq_q;
  // Mask comes up set after reset, as a CPU does, until software clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq_mask <= 1'b1;
      irq_q <= 1'b0;
      taken_count <= 0;
    end else begin
      cpu_irq_mask <= mask_req;
      irq_q <= timer_irq_req;
      if (timer_irq_req && !irq_q) begin
        taken_count <= taken_count + 1;
      end
    end
  end
endmodule // cpu_irq_model
`default_nettype wire

// *** tick_source_if.sv ***
// Carrier between the register core and the count clock selector
`default_nettype none
interface tick_source_if;
  logic [2:0] sel;
  logic ext_pin;
  logic tick;
  modport src (input sel, input ext_pin, output tick);
  modport user (output sel, output ext_pin, input tick);
endinterface
`default_nettype wire

// *** timer_pkg.sv ***
// Constants, register map and field layout of the auto-reload interval timer
// Functional notes
// - A 13-bit prescaler counts up by one on every system clock cycle.
// - An 8-bit read/write mode register selects auto-reload and the count clock.
// - The 8-bit count value is readable and counts up on each selected clock edge.
// - Count clock is system clock over 8192, 2048, 512, 256, 64, 16, 4, or external.
// - An 8-bit write-only load register holds the auto-reload value.
// - In auto-reload the count starts from the load value and reloads it on overflow.
// - Each overflow sets the request flag; zero means no request.
// - The enable bit set to one lets the request flag through as an interrupt.
// - Interrupt starts only with flag one, enable one and CPU mask bit zero.
// - Interrupt interval equals count clock period times 256 minus reload value.
// - Writing mode value fc selects auto-reload with system clock over 64.
`default_nettype none
package timer_pkg;
  localparam int ADDR_W = 18;
  localparam int PRESC_W = 13;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [15:0] MODE_IDX = 16'hffb2;
  localparam logic [15:0] COUNT_IDX = 16'hffb3;
  localparam logic [15:0] IEN_IDX = 16'hfff5;
  localparam logic [15:0] IRQ_IDX = 16'hfff7;
  localparam logic [ADDR_W-1:0] MODE_ADDR = {MODE_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] COUNT_ADDR = {COUNT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] IEN_ADDR = {IEN_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] IRQ_ADDR = {IRQ_IDX, 2'h0};
  // Mode register layout
  localparam int MODE_AUTO_BIT = 7;
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_SEL_W = 3;
  localparam logic [3:0] MODE_RSV_ONES = 4'hf;
  localparam int IRQ_BIT = 5;
  // Count clock selections
  localparam logic [2:0] SEL_DIV8192 = 3'h0;
  localparam logic [2:0] SEL_DIV2048 = 3'h1;
  localparam logic [2:0] SEL_DIV512 = 3'h2;
  localparam logic [2:0] SEL_DIV256 = 3'h3;
  localparam logic [2:0] SEL_DIV64 = 3'h4;
  localparam logic [2:0] SEL_DIV16 = 3'h5;
  localparam logic [2:0] SEL_DIV4 = 3'h6;
  localparam logic [2:0] SEL_EXT = 3'h7;
  // Reset values
  localparam logic RST_AUTO = 1'b0;
  localparam logic [2:0] RST_SEL = SEL_DIV8192;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic RST_IEN = 1'b0;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [8:0] COUNT_SPAN = 9'h100;
  localparam logic [7:0] MODE_AUTO_DIV64 = 8'hfc;
endpackage
`default_nettype wire
